/* shared/lpc_consts.svh */
// Overview of operation
// - current-limit config register at address 0x4, written and read back by host
// - protection-recovery config register at address 0x5, written and read back by host
// - bit 2 of 0x4 set turns pulsed current limiting off, clear turns it on
// - latched overload mode: overload flag clears voltage select and disables output
// - automatic overload mode: output returns with kept voltage select when flag clears
// - latched thermal mode: overtemperature flag clears voltage select and disables output
// - automatic thermal mode: output returns with kept voltage select when flag clears
// - bit 7 of 0x5 picks converter compensation: 1 ceramic, 0 electrolytic
// - both configuration registers clear to zero at reset
// - overload flag, status bit 0, reads 1 while output current exceeds limit
// - overtemperature flag, status bit 6, reads 1 while overtemperature is detected
// - voltage select lives in bits 0 to 3 of data register 0x2
// - reading data register 0x2 returns the byte last written to it, less bits 0 to 3 cleared by a latched trip; 0x3 reads 0
`ifndef LPC_CONSTS_SVH
`define LPC_CONSTS_SVH

// ***********************************************
// register addresses
// ***********************************************
`define LPC_ADDR_STATUS1   8'h00
`define LPC_ADDR_STATUS2   8'h01
`define LPC_ADDR_VOLT      8'h02
`define LPC_ADDR_TONE      8'h03
`define LPC_ADDR_CLIM      8'h04
`define LPC_ADDR_PREC      8'h05

// ***********************************************
// field positions and values
// ***********************************************
`define LPC_RESET_BYTE     8'h00
`define LPC_ZERO_BYTE      8'h00
`define LPC_VOLT_MASK      8'h0F
`define LPC_VOLT_OFF       4'h0
`define LPC_BIT_PULSE_OFF  2
`define LPC_BIT_OL_LATCH   3
`define LPC_BIT_OT_LATCH   6
`define LPC_BIT_COMP       7
`define LPC_BIT_OL_FLAG    0
`define LPC_BIT_OT_FLAG    6

`endif

/* shared/lpc_pkg.sv */
package lpc_pkg;

   // ***********************************************
   // register port request
   // ***********************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] data;
   } lpc_req_t;

   // ***********************************************
   // protection event levels
   // ***********************************************
   typedef struct packed {
      logic overload;
      logic overtemp;
   } lpc_fault_t;

   // ***********************************************
   // supply state
   // ***********************************************
   typedef enum logic [1:0] {
      LPC_OFF,
      LPC_ON,
      LPC_FAULT,
      LPC_HELD
   } lpc_state_t;

endpackage : lpc_pkg

/* hw/lpc_byte_reg.sv */
`timescale 1ns/100ps
`include "lpc_consts.svh"

module lpc_byte_reg #(
   parameter logic [7:0] CLR_MASK = 8'h00
) (
   input  wire logic       clock_in,
   input  wire logic       srst_in,
   input  wire logic       wr_en_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       clr_in,
   output logic [7:0]      value_out
);

   logic [7:0] next_value;

   // clear of the masked bits wins over a host write
   assign next_value = clr_in   ? (wr_en_in ? wr_data_in : value_out) & ~CLR_MASK :
                       wr_en_in ? wr_data_in : value_out;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         value_out <= `LPC_RESET_BYTE;
      end else begin
         value_out <= next_value;
      end
   end

endmodule : lpc_byte_reg

/* hw/lpc_recovery.sv */
`timescale 1ns/100ps
`include "lpc_consts.svh"

module lpc_recovery (
   input  wire logic clock_in,
   input  wire logic srst_in,
   input  wire logic flag_in,
   input  wire logic latched_in,
   input  wire logic volt_wr_in,
   output logic      clear_out,
   output logic      block_out,
   output logic      held_out
);

   logic next_held;

   // latched mode clears the voltage select while the flag stands
   assign clear_out = flag_in & latched_in;

   // held until the host rewrites voltage select with the flag gone
   assign next_held = clear_out | (held_out & ~(volt_wr_in & ~flag_in));

   // output is blocked by the flag itself or by a latched trip
   assign block_out = flag_in | next_held;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         held_out <= 1'b0;
      end else begin
         held_out <= next_held;
      end
   end

endmodule : lpc_recovery

/* hw/lpc_regs.sv */
`timescale 1ns/100ps
`include "lpc_consts.svh"

module lpc_regs (
   input  wire logic                clock_in,
   input  wire logic                srst_in,
   input  wire lpc_pkg::lpc_req_t   req_in,
   input  wire lpc_pkg::lpc_fault_t fault_in,
   output logic [7:0]               rd_data_out,
   output logic                     rd_valid_out,
   output logic [3:0]               voltage_select_out,
   output logic                     supply_enable_out,
   output logic                     pulsed_limit_disable_out,
   output logic                     compensation_ceramic_out,
   output logic                     overload_flag_out,
   output logic                     overtemp_flag_out,
   output lpc_pkg::lpc_state_t      state_out
);

   // ***********************************************
   // declarations
   // ***********************************************
   logic [7:0]          volt_byte;
   logic [7:0]          clim_byte;
   logic [7:0]          prec_byte;
   logic                overload_flag;
   logic                overtemp_flag;
   logic                wr_volt;
   logic                wr_clim;
   logic                wr_prec;
   logic                ol_clear;
   logic                ot_clear;
   logic                ol_block;
   logic                ot_block;
   logic                volt_clear;
   logic                overload_latched_recovery;
   logic                thermal_latched_recovery;
   logic [7:0]          status1_byte;
   logic [7:0]          rd_mux;
   logic [7:0]          next_rd_data;
   logic                next_enable;
   logic [3:0]          next_volt;
   logic [7:0]          next_clim;
   logic [7:0]          next_prec;
   lpc_pkg::lpc_state_t next_state;

   // ***********************************************
   // write decode
   // ***********************************************
   assign wr_volt = req_in.wr & (req_in.addr == `LPC_ADDR_VOLT);
   assign wr_clim = req_in.wr & (req_in.addr == `LPC_ADDR_CLIM);
   assign wr_prec = req_in.wr & (req_in.addr == `LPC_ADDR_PREC);

   // ***********************************************
   // protection flags
   // ***********************************************
   assign overload_flag = fault_in.overload;
   assign overtemp_flag = fault_in.overtemp;

   // ***********************************************
   // recovery mode bits
   // ***********************************************
   assign overload_latched_recovery = prec_byte[`LPC_BIT_OL_LATCH];
   assign thermal_latched_recovery  = prec_byte[`LPC_BIT_OT_LATCH];

   // ***********************************************
   // configuration registers
   // ***********************************************
   lpc_byte_reg #(
      .CLR_MASK (`LPC_ZERO_BYTE)
   ) u_clim (
      .clock_in   (clock_in),
      .srst_in    (srst_in),
      .wr_en_in   (wr_clim),
      .wr_data_in (req_in.data),
      .clr_in     (1'b0),
      .value_out  (clim_byte)
   );

   lpc_byte_reg #(
      .CLR_MASK (`LPC_ZERO_BYTE)
   ) u_prec (
      .clock_in   (clock_in),
      .srst_in    (srst_in),
      .wr_en_in   (wr_prec),
      .wr_data_in (req_in.data),
      .clr_in     (1'b0),
      .value_out  (prec_byte)
   );

   // ***********************************************
   // voltage select register
   // ***********************************************
   lpc_byte_reg #(
      .CLR_MASK (`LPC_VOLT_MASK)
   ) u_volt (
      .clock_in   (clock_in),
      .srst_in    (srst_in),
      .wr_en_in   (wr_volt),
      .wr_data_in (req_in.data),
      .clr_in     (volt_clear),
      .value_out  (volt_byte)
   );

   // ***********************************************
   // overload recovery
   // ***********************************************
   lpc_recovery u_ol (
      .clock_in   (clock_in),
      .srst_in    (srst_in),
      .flag_in    (overload_flag),
      .latched_in (overload_latched_recovery),
      .volt_wr_in (wr_volt),
      .clear_out  (ol_clear),
      .block_out  (ol_block),
      .held_out   ()
   );

   // ***********************************************
   // thermal recovery
   // ***********************************************
   lpc_recovery u_ot (
      .clock_in   (clock_in),
      .srst_in    (srst_in),
      .flag_in    (overtemp_flag),
      .latched_in (thermal_latched_recovery),
      .volt_wr_in (wr_volt),
      .clear_out  (ot_clear),
      .block_out  (ot_block),
      .held_out   ()
   );

   // ***********************************************
   // voltage select clear and output enable
   // ***********************************************
   assign volt_clear = ol_clear | ot_clear;

   // a fault clear wins over a host write in the same cycle
   assign next_volt = volt_clear ? `LPC_VOLT_OFF :
                      wr_volt    ? req_in.data[3:0] :
                                   volt_byte[3:0];

   // enable only when neither fault blocks the supply
   assign next_enable = ~ol_block & ~ot_block;

   // configuration pins follow a write at the edge that takes it
   assign next_clim = wr_clim ? req_in.data : clim_byte;
   assign next_prec = wr_prec ? req_in.data : prec_byte;

   // ***********************************************
   // supply state
   // ***********************************************
   always_comb begin
      case ({overload_flag | overtemp_flag, ol_block | ot_block, next_volt != `LPC_VOLT_OFF})
         3'b000  : next_state = lpc_pkg::LPC_OFF;
         3'b001  : next_state = lpc_pkg::LPC_ON;
         3'b010  : next_state = lpc_pkg::LPC_HELD;
         3'b011  : next_state = lpc_pkg::LPC_HELD;
         3'b110  : next_state = lpc_pkg::LPC_FAULT;
         3'b111  : next_state = lpc_pkg::LPC_FAULT;
         default : next_state = lpc_pkg::LPC_OFF;
      endcase
   end

   // ***********************************************
   // status byte
   // ***********************************************
   always_comb begin
      status1_byte                = `LPC_ZERO_BYTE;
      status1_byte[`LPC_BIT_OL_FLAG] = overload_flag;
      status1_byte[`LPC_BIT_OT_FLAG] = overtemp_flag;
   end

   // ***********************************************
   // read selection
   // ***********************************************
   always_comb begin
      case (req_in.addr)
         `LPC_ADDR_STATUS1 : rd_mux = status1_byte;
         `LPC_ADDR_STATUS2 : rd_mux = `LPC_ZERO_BYTE;
         `LPC_ADDR_VOLT    : rd_mux = volt_byte;
         `LPC_ADDR_CLIM    : rd_mux = clim_byte;
         `LPC_ADDR_PREC    : rd_mux = prec_byte;
         default           : rd_mux = `LPC_ZERO_BYTE;
      endcase
   end

   assign next_rd_data = req_in.rd ? rd_mux : rd_data_out;

   // ***********************************************
   // output flops
   // ***********************************************
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rd_data_out              <= `LPC_ZERO_BYTE;
         rd_valid_out             <= 1'b0;
         voltage_select_out       <= `LPC_VOLT_OFF;
         supply_enable_out        <= 1'b0;
         pulsed_limit_disable_out <= 1'b0;
         compensation_ceramic_out <= 1'b0;
         overload_flag_out        <= 1'b0;
         overtemp_flag_out        <= 1'b0;
         state_out                <= lpc_pkg::LPC_OFF;
      end else begin
         rd_data_out              <= next_rd_data;
         rd_valid_out             <= req_in.rd;
         voltage_select_out       <= next_volt;
         supply_enable_out        <= next_enable;
         pulsed_limit_disable_out <= next_clim[`LPC_BIT_PULSE_OFF];
         compensation_ceramic_out <= next_prec[`LPC_BIT_COMP];
         overload_flag_out        <= overload_flag;
         overtemp_flag_out        <= overtemp_flag;
         state_out                <= next_state;
      end
   end

endmodule : lpc_regs

/* dv/lpc_regs_chk.sv */
`timescale 1ns/100ps
module lpc_regs_chk (
   input wire logic                clock_in,
   input wire logic                srst_in,
   input wire lpc_pkg::lpc_req_t   req_in,
   input wire lpc_pkg::lpc_fault_t fault_in,
   input wire logic                rd_valid_out,
   input wire logic [3:0]          voltage_select_out,
   input wire logic                supply_enable_out,
   input wire logic                pulsed_limit_disable_out,
   input wire logic                compensation_ceramic_out,
   input wire logic                overload_flag_out,
   input wire logic                overtemp_flag_out
);
   // ****
   // recovery mode copy and properties
   // ****
   logic [7:0] mode_q;
   wire        wr_lim  = req_in.wr && req_in.addr == 8'h04;
   wire        wr_mode = req_in.wr && req_in.addr == 8'h05;
   wire        wr_volt = req_in.wr && req_in.addr == 8'h02;
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         mode_q <= 8'h00;
      end else if (wr_mode) begin
         mode_q <= req_in.data;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);
   read_valid_a: assert property (req_in.rd |=> rd_valid_out)
      else $error("read gave no valid pulse");
   reset_zero_a: assert property ($past(srst_in) |-> voltage_select_out == 4'h0
      && !pulsed_limit_disable_out && !compensation_ceramic_out) else $error("outputs not clear after reset");
   limit_bit_a: assert property (wr_lim |=> pulsed_limit_disable_out == $past(req_in.data[2]))
      else $error("pulsed limit output wrong");
   comp_bit_a: assert property (wr_mode |=> compensation_ceramic_out == $past(req_in.data[7]))
      else $error("compensation output wrong");
   ovl_latch_a: assert property (mode_q[3] && fault_in.overload
      |=> voltage_select_out == 4'h0 && !supply_enable_out) else $error("overload latch failed");
   hot_latch_a: assert property (mode_q[6] && fault_in.overtemp
      |=> voltage_select_out == 4'h0 && !supply_enable_out) else $error("thermal latch failed");
   fault_block_a: assert property (fault_in != 2'h0 |=> !supply_enable_out)
      else $error("output on during fault");
   auto_return_a: assert property ((!mode_q[3] && !mode_q[6] && $past(fault_in) != 2'h0
      && fault_in == 2'h0) ##1 fault_in == 2'h0 |=> supply_enable_out) else $error("no auto return");
   volt_write_a: assert property (wr_volt && fault_in == 2'h0
      |=> voltage_select_out == $past(req_in.data[3:0])) else $error("voltage select not written");
   flag_copy_a: assert property (1'h1 |=> {overload_flag_out, overtemp_flag_out} == $past(fault_in))
      else $error("fault flags wrong");
endmodule : lpc_regs_chk
bind lpc_regs lpc_regs_chk chk (.clock_in, .srst_in, .req_in, .fault_in, .rd_valid_out, .voltage_select_out,
   .supply_enable_out, .pulsed_limit_disable_out, .compensation_ceramic_out, .overload_flag_out,
   .overtemp_flag_out);

/* dv/lpc_host.sv */
`timescale 1ns/100ps
module lpc_host (
   input  wire logic         clock_in,
   input  wire logic         rd_valid_in,
   input  wire logic [7:0]   rd_data_in,
   output lpc_pkg::lpc_req_t req_out
);
   // ****
   // byte transfers, idle lines inverted
   // ****
   initial req_out = '0;
   task automatic put_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      req_out <= '{1'h1, 1'h0, a, d};
      @(posedge clock_in);
      req_out <= '{1'h0, 1'h0, ~a, ~d};
      #1;
   endtask : put_byte
   task automatic get_byte(input logic [7:0] a, output logic [8:0] vd);
      @(posedge clock_in);
      req_out <= '{1'h0, 1'h1, a, 8'h00};
      @(posedge clock_in);
      req_out <= '{1'h0, 1'h0, ~a, 8'hFF};
      #1;
      vd = {rd_valid_in, rd_data_in};
   endtask : get_byte
endmodule : lpc_host

/* dv/tb.sv */
`timescale 1ns/100ps
module tb;
   logic                clock_in;
   logic                srst_in;
   lpc_pkg::lpc_req_t   req_in;
   lpc_pkg::lpc_fault_t fault_in;
   logic [7:0]          rd_data_out;
   logic                rd_valid_out;
   logic [3:0]          volt;
   logic                sup_en;
   logic                lim_off;
   logic                ceramic;
   logic                ovl;
   logic                hot;
   lpc_pkg::lpc_state_t state_out;
   logic [8:0]          got;
   logic [7:0]          r4;
   logic [7:0]          r5;
   logic [7:0]          wa[5] = '{8'h04, 8'h05, 8'h04, 8'h05, 8'h07};
   logic [7:0]          wd[5] = '{8'h04, 8'h80, 8'h00, 8'h00, 8'hFF};
   int                  err_count = 0;
   int                  total_checks = 0;
   // ****
   // clock, design, host, tasks
   // ****
   initial begin
      clock_in = 1'h0;
      forever #5 clock_in = ~clock_in;
   end
   lpc_regs uut (.clock_in, .srst_in, .req_in, .fault_in, .rd_data_out, .rd_valid_out, .voltage_select_out(volt),
      .supply_enable_out(sup_en), .pulsed_limit_disable_out(lim_off), .compensation_ceramic_out(ceramic),
      .overload_flag_out(ovl), .overtemp_flag_out(hot), .state_out);
   lpc_host host (.clock_in, .rd_valid_in(rd_valid_out), .rd_data_in(rd_data_out), .req_out(req_in));
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host.get_byte(a, got);
      check("read", got, {1'h1, exp});
   endtask : rd_chk
   task automatic set_fault(input logic [1:0] f);
      @(posedge clock_in);
      fault_in <= f;
      @(posedge clock_in);
      #1;
   endtask : set_fault
   task automatic latch_case(input logic [7:0] mode, input logic [1:0] f);
      host.put_byte(8'h05, mode);
      host.put_byte(8'h02, 8'h03);
      set_fault(f);
      check("volt", 9'(volt), 9'h000);
      check("enable", 9'(sup_en), 9'h000);
      set_fault(2'h0);
      set_fault(2'h0);
      check("held", 9'(sup_en), 9'h000);
      check("state", 9'(state_out), 9'(lpc_pkg::LPC_HELD));
      host.put_byte(8'h02, 8'h03);
      check("volt", 9'(volt), 9'h003);
      check("enable", 9'(sup_en), 9'h001);
      check("state", 9'(state_out), 9'(lpc_pkg::LPC_ON));
   endtask : latch_case
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      #100000;
      err_count++;
      complete_run();
   end
   initial begin
      srst_in = 1'h1;
      fault_in = 2'h0;
      r4 = 8'h00;
      r5 = 8'h00;
      repeat (5) @(posedge clock_in);
      srst_in <= 1'h0;
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h05, 8'h00);
      $display("test reset done");
      foreach (wa[i]) begin
         host.put_byte(wa[i], wd[i]);
         if (wa[i] == 8'h04) r4 = wd[i];
         if (wa[i] == 8'h05) r5 = wd[i];
         rd_chk(wa[i], wa[i] == 8'h04 ? r4 : (wa[i] == 8'h05 ? r5 : 8'h00));
         check("limit", 9'(lim_off), 9'(r4[2]));
         check("comp", 9'(ceramic), 9'(r5[7]));
      end
      $display("test access done");
      latch_case(8'h08, 2'h2);
      latch_case(8'h40, 2'h1);
      $display("test latched done");
      host.put_byte(8'h05, 8'h00);
      host.put_byte(8'h02, 8'h05);
      set_fault(2'h2);
      check("ovl", 9'(ovl), 9'h001);
      check("state", 9'(state_out), 9'(lpc_pkg::LPC_FAULT));
      check("enable", 9'(sup_en), 9'h000);
      set_fault(2'h3);
      rd_chk(8'h00, 8'h41);
      set_fault(2'h1);
      check("hot", 9'(hot), 9'h001);
      check("enable", 9'(sup_en), 9'h000);
      set_fault(2'h0);
      set_fault(2'h0);
      check("enable", 9'(sup_en), 9'h001);
      check("volt", 9'(volt), 9'h005);
      rd_chk(8'h02, 8'h05);
      $display("test auto done");
      host.put_byte(8'h04, 8'h04);
      @(posedge clock_in);
      srst_in <= 1'h1;
      @(posedge clock_in);
      srst_in <= 1'h0;
      rd_chk(8'h04, 8'h00);
      check("volt", 9'(volt), 9'h000);
      check("limit", 9'(lim_off), 9'h000);
      check("state", 9'(state_out), 9'(lpc_pkg::LPC_OFF));
      $display("test rereset done");
      complete_run();
   end
endmodule : tb
